/* File: src/power_on_off_request_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "arbiter_params.svh"

module debounce_filter #(
    parameter int   N    = 4,
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // filtered level
    input  wire logic din,
    output var  logic dout
);
    localparam int W = $clog2(N + 1);
    logic [W-1:0] cnt_q;
    wire logic    differs = (din != dout);
    wire logic    expired = (cnt_q == W'(N - 1));
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            dout  <= INIT;
        end else if (!differs) begin
            cnt_q <= '0;
        end else if (expired) begin
            cnt_q <= '0;
            dout  <= din;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : debounce_filter

module power_on_off_request_arbiter #(
    parameter int   IRQ_W          = 8,
    parameter logic PD_ACT_HIGH    = 1'b1,
    parameter logic RI_ACT_HIGH    = 1'b0,
    parameter int   HOLD_DEB_CYC   = `HOLD_DEB_US * (`CLK_HZ / 1000000),
    parameter int   RI_OFF_CYC     = `RSTIN_OFF_US * (`CLK_HZ / 1000000),
    parameter int   RI_ON_CYC      = `RSTIN_ON_US * (`CLK_HZ / 1000000),
    parameter int   LONG_PRESS_CYC = `LONG_PRESS_MS * (`CLK_HZ / 1000),
    parameter int   DLY_UNIT_CYC   = `DLY_UNIT_MS * (`CLK_HZ / 1000),
    parameter int   WDOG_UNIT_CYC  = `WDOG_UNIT_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // register port
    input  wire arbiter_pkg::reg_req_type reg_req,
    output var  logic [31:0]              rd_data,
    // system pins
    input  wire logic                     power_button_input,
    input  wire logic                     hold_on_input,
    input  wire logic                     power_down_input,
    input  wire logic                     reset_request_input,
    // monitor events
    input  wire logic                     supply_high_ok,
    input  wire logic                     supply_low_fault,
    input  wire logic                     die_overtemp,
    input  wire logic                     thermal_shutdown,
    input  wire logic                     converter_shutdown_event,
    input  wire logic [IRQ_W-1:0]         irq_lines,
    // sleep and wake requests
    input  wire logic                     sleep_request,
    input  wire logic                     wake_request,
    // sequencer side
    input  wire logic                     seq_done,
    output var  arbiter_pkg::seq_req_type seq_q,
    output var  arbiter_pkg::state_type   state_q,
    output var  logic [`SRC_N-1:0]        cause_q
);
    localparam int SW = IRQ_W + 9;
    logic [SW-1:0]    sync1_q;
    logic [SW-1:0]    sync2_q;
    logic [IRQ_W-1:0] irq_s;
    logic             pb_s, hold_s, pd_s, ri_s, shi_s;
    logic             slo_s, hot_s, th_s, conv_s;
    logic             pb_d_q, hold_deb, ri_off_deb, ri_on_deb, pb_long;
    logic [2:0]       cfg_q;
    logic [8:0]       act_q, depth_q;
    logic [IRQ_W-1:0] on_sel_q;
    logic             device_on_q, wd_en_q, wd_lock_q;
    logic [3:0]       wd_per_q;
    logic [31:0]      wd_cnt_q, cnt_q, cnt_d;
    logic             wd_ev_q, soft_ev_q, conv_ev_q, from_slp_q, from_slp_d;
    arbiter_pkg::state_type     state_d;
    arbiter_pkg::seq_kind_type  kind_d;
    logic             start_d, wide_d, cold_d;
    logic [`SRC_N-1:0] cause_d;

    // two-flop synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {irq_lines, converter_shutdown_event,
                        thermal_shutdown, die_overtemp, supply_low_fault,
                        supply_high_ok, reset_request_input,
                        power_down_input, hold_on_input, power_button_input};
            sync2_q <= sync1_q;
        end
    end
    assign {irq_s, conv_s, th_s, hot_s, slo_s, shi_s, ri_s, pd_s, hold_s,
            pb_s} = sync2_q;

    wire logic pd_act = (pd_s == PD_ACT_HIGH);
    wire logic ri_lvl = (ri_s == RI_ACT_HIGH);

    debounce_filter #(.N(HOLD_DEB_CYC), .INIT(1'b0)) u_hold (
        .clk(clk), .rst(rst), .din(hold_s), .dout(hold_deb));
    debounce_filter #(.N(RI_OFF_CYC), .INIT(1'b0)) u_ri_off (
        .clk(clk), .rst(rst), .din(ri_lvl), .dout(ri_off_deb));
    debounce_filter #(.N(RI_ON_CYC), .INIT(1'b0)) u_ri_on (
        .clk(clk), .rst(rst), .din(ri_lvl), .dout(ri_on_deb));
    debounce_filter #(.N(LONG_PRESS_CYC), .INIT(1'b1)) u_pb (
        .clk(clk), .rst(rst), .din(pb_s), .dout(pb_long));

    // register decode
    wire logic a_cfg  = (reg_req.addr == `A_UNIT_CFG);
    wire logic a_act  = (reg_req.addr == `A_OFF_ACT);
    wire logic a_dep  = (reg_req.addr == `A_DEPTH);
    wire logic a_sel  = (reg_req.addr == `A_ON_SEL);
    wire logic a_ctl  = (reg_req.addr == `A_CTRL);
    wire logic a_wd   = (reg_req.addr == `A_WDOG);
    wire logic a_stat = (reg_req.addr == `A_STATUS);
    wire logic wr_ctl = reg_req.wr & a_ctl;
    wire logic wr_wd  = reg_req.wr & a_wd & !wd_lock_q;
    wire logic wr_kick = reg_req.wr & (reg_req.addr == `A_KICK);
    wire logic soft_set = wr_ctl & reg_req.wdata[`CTRL_SOFT_RESET];

    // request arbitration inputs
    wire logic pb_fall = pb_d_q & !pb_s;
    wire logic irq_on  = |(irq_s & on_sel_q);
    wire logic on_req  = pb_fall | hold_deb | irq_on;
    wire logic gate    = !shi_s | hot_s | pd_act | ri_on_deb;
    wire logic keep_lost = !device_on_q & !hold_deb;
    logic [`SRC_N-1:0] off_vec;
    assign off_vec[`SRC_LONG_PRESS] = !pb_long;
    assign off_vec[`SRC_POWER_DOWN] = pd_act;
    assign off_vec[`SRC_WATCHDOG]   = wd_ev_q;
    assign off_vec[`SRC_THERMAL]    = th_s;
    assign off_vec[`SRC_RESET_IN]   = ri_off_deb;
    assign off_vec[`SRC_SOFT_RESET] = soft_ev_q;
    assign off_vec[`SRC_KEEP_LOST]  = keep_lost;
    assign off_vec[`SRC_SUPPLY_LOW] = slo_s;
    assign off_vec[`SRC_CONVERTER]  = conv_ev_q;
    wire logic off_any  = |off_vec;
    wire logic off_lvl  = |(off_vec & ~`KEEP_MASK);
    wire logic on_ok    = on_req & !gate & !off_lvl;
    wire logic zero_src = |(off_vec & ~`DLY_MASK);
    wire logic [1:0] dly_sel = cfg_q[`CFG_DLY_LSB+:2];
    wire logic off_zero = zero_src | (dly_sel == 2'h0);
    wire logic [2:0] dly_mult = (dly_sel == `DLY_SEL_X4) ? 3'h4
                                                         : {1'b0, dly_sel};
    wire logic [31:0] dly_load =
        32'(32'(dly_mult) * 32'(DLY_UNIT_CYC) - 32'h1);

    // watchdog
    wire logic wd_run = wd_en_q & (state_q == arbiter_pkg::ST_ACT ||
                                   state_q == arbiter_pkg::ST_SLEEP);
    wire logic [31:0] wd_lim =
        32'((32'(wd_per_q) + 32'h1) * 32'(WDOG_UNIT_CYC));
    wire logic wd_to = wd_run & (wd_cnt_q == wd_lim - 32'h1);

    // latched events clear in OFF and when a down sequence is launched
    wire logic down_kind = (kind_d == arbiter_pkg::SEQ_ACT_TO_OFF) ||
                           (kind_d == arbiter_pkg::SEQ_SLP_TO_OFF);
    wire logic ev_clr = (state_q == arbiter_pkg::ST_OFF) |
                        (start_d & down_kind);
    wire logic dn_end = (state_q == arbiter_pkg::ST_DN) & seq_done;
    wire logic restart = dn_end & seq_q.cold & !gate;
    wire logic keep_cause = |(cause_d & `KEEP_MASK);

    // power transition arbitration
    always_comb begin
        state_d    = state_q;
        start_d    = 1'b0;
        kind_d     = seq_q.kind;
        cause_d    = cause_q;
        from_slp_d = from_slp_q;
        cnt_d      = (cnt_q == 32'h0) ? cnt_q : cnt_q - 32'h1;
        unique case (state_q)
            arbiter_pkg::ST_OFF: begin
                if (on_ok) begin
                    state_d = arbiter_pkg::ST_UP;
                    start_d = 1'b1;
                    kind_d  = arbiter_pkg::SEQ_OFF_TO_ACT;
                end
            end
            arbiter_pkg::ST_UP, arbiter_pkg::ST_WAKE: begin
                if (seq_done) begin
                    state_d = arbiter_pkg::ST_ACT;
                end
            end
            arbiter_pkg::ST_TO_SLP: begin
                if (seq_done) begin
                    state_d = arbiter_pkg::ST_SLEEP;
                end
            end
            arbiter_pkg::ST_ACT, arbiter_pkg::ST_SLEEP: begin
                if (off_any) begin
                    cause_d    = off_vec;
                    from_slp_d = (state_q == arbiter_pkg::ST_SLEEP);
                    if (off_zero) begin
                        state_d = arbiter_pkg::ST_DN;
                        start_d = 1'b1;
                        kind_d  = from_slp_d ? arbiter_pkg::SEQ_SLP_TO_OFF
                                             : arbiter_pkg::SEQ_ACT_TO_OFF;
                    end else begin
                        state_d = arbiter_pkg::ST_DLY;
                        cnt_d   = dly_load;
                    end
                end else if (state_q == arbiter_pkg::ST_ACT &&
                             sleep_request) begin
                    state_d = arbiter_pkg::ST_TO_SLP;
                    start_d = 1'b1;
                    kind_d  = arbiter_pkg::SEQ_ACT_TO_SLP;
                end else if (state_q == arbiter_pkg::ST_SLEEP &&
                             wake_request) begin
                    state_d = arbiter_pkg::ST_WAKE;
                    start_d = 1'b1;
                    kind_d  = arbiter_pkg::SEQ_SLP_TO_ACT;
                end
            end
            arbiter_pkg::ST_DLY: begin
                cause_d = cause_q | off_vec;
                if (cnt_q == 32'h0 || zero_src) begin
                    state_d = arbiter_pkg::ST_DN;
                    start_d = 1'b1;
                    kind_d  = from_slp_q ? arbiter_pkg::SEQ_SLP_TO_OFF
                                         : arbiter_pkg::SEQ_ACT_TO_OFF;
                end
            end
            arbiter_pkg::ST_DN: begin
                if (restart) begin
                    state_d = arbiter_pkg::ST_UP;
                    start_d = 1'b1;
                    kind_d  = arbiter_pkg::SEQ_OFF_TO_ACT;
                end else if (dn_end) begin
                    state_d = arbiter_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = arbiter_pkg::ST_OFF;
            end
        endcase
    end

    // depth and action of the captured causes
    assign wide_d = (start_d & down_kind)
                  ? (|(cause_d & depth_q) & !keep_cause)
                  : seq_q.wide;
    assign cold_d = (start_d & down_kind)
                  ? (|(cause_d & act_q) & !keep_cause)
                  : seq_q.cold;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= arbiter_pkg::ST_OFF;
            seq_q      <= '{1'b0, arbiter_pkg::SEQ_NONE, 1'b0, 1'b0};
            cause_q    <= '0;
            cnt_q      <= 32'h0;
            from_slp_q <= 1'b0;
            pb_d_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            seq_q      <= '{start_d, kind_d, wide_d, cold_d};
            cause_q    <= cause_d;
            cnt_q      <= cnt_d;
            from_slp_q <= from_slp_d;
            pb_d_q     <= pb_s;
        end
    end

    // event latches, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_ev_q   <= 1'b0;
            soft_ev_q <= 1'b0;
            conv_ev_q <= 1'b0;
            wd_cnt_q  <= 32'h0;
        end else begin
            wd_ev_q   <= (wd_ev_q & !ev_clr) | wd_to;
            soft_ev_q <= (soft_ev_q & !ev_clr) | soft_set;
            conv_ev_q <= (conv_ev_q & !ev_clr) |
                         (conv_s & cfg_q[`CFG_CONV_EN]);
            wd_cnt_q  <= (!wd_run | wr_kick | wd_to) ? 32'h0
                                                     : wd_cnt_q + 32'h1;
        end
    end

    // software registers; end of a down sequence applies the reset depth
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q       <= `RV_UNIT_CFG;
            act_q       <= `RV_OFF_ACT;
            depth_q     <= `RV_DEPTH;
            on_sel_q    <= `RV_ON_SEL;
            device_on_q <= 1'b0;
            wd_en_q     <= 1'b0;
            wd_lock_q   <= 1'b0;
            wd_per_q    <= 4'h0;
        end else begin
            if (dn_end) begin
                wd_en_q   <= 1'b0;
                wd_lock_q <= 1'b0;
                if (!restart) begin
                    device_on_q <= 1'b0;
                end
                if (seq_q.wide) begin
                    cfg_q    <= `RV_UNIT_CFG;
                    act_q    <= `RV_OFF_ACT;
                    depth_q  <= `RV_DEPTH;
                    on_sel_q <= `RV_ON_SEL;
                end
            end
            if (reg_req.wr & a_cfg) begin
                cfg_q <= reg_req.wdata[2:0];
            end
            if (reg_req.wr & a_act) begin
                act_q <= reg_req.wdata[8:0];
            end
            if (reg_req.wr & a_dep) begin
                depth_q <= reg_req.wdata[8:0];
            end
            if (reg_req.wr & a_sel) begin
                on_sel_q <= reg_req.wdata[IRQ_W-1:0];
            end
            if (wr_ctl) begin
                device_on_q <= reg_req.wdata[`CTRL_DEVICE_ON];
            end
            if (wr_wd) begin
                wd_en_q   <= reg_req.wdata[`WD_EN];
                wd_lock_q <= reg_req.wdata[`WD_LOCK];
                wd_per_q  <= reg_req.wdata[`WD_PER_LSB+:4];
            end
        end
    end

    // read mux, unmapped reads return zero
    wire logic [31:0] rd_mux =
        a_cfg  ? 32'(cfg_q) :
        a_act  ? 32'(act_q) :
        a_dep  ? 32'(depth_q) :
        a_sel  ? 32'(on_sel_q) :
        a_ctl  ? 32'(device_on_q) :
        a_wd   ? 32'({wd_per_q, wd_lock_q, wd_en_q}) :
        a_stat ? 32'({gate, cause_q, state_q}) : 32'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 32'h0;
        end else begin
            rd_data <= reg_req.rd ? rd_mux : 32'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_up_start;
        seq_q.start && seq_q.kind == arbiter_pkg::SEQ_OFF_TO_ACT;
    endsequence
    sequence s_down_start;
        seq_q.start && (seq_q.kind == arbiter_pkg::SEQ_ACT_TO_OFF ||
                        seq_q.kind == arbiter_pkg::SEQ_SLP_TO_OFF);
    endsequence
    wire logic in_run = (state_q == arbiter_pkg::ST_ACT) ||
                        (state_q == arbiter_pkg::ST_SLEEP);
    wire logic in_off = (state_q == arbiter_pkg::ST_OFF);

    AST_ON_START: assert property (in_off && on_ok |=> s_up_start)
        else $error("on request did not start power-up");
    AST_GATED: assert property (in_off && gate |=> !seq_q.start)
        else $error("power-up started while gated");
    AST_HOT: assert property (in_off && hot_s |=> in_off)
        else $error("left off while overtemperature");
    AST_OFF_RUN: assert property (in_run && off_any |=>
        state_q inside {arbiter_pkg::ST_DLY, arbiter_pkg::ST_DN})
        else $error("off request not taken");
    AST_PRIO: assert property (state_q == arbiter_pkg::ST_ACT && off_any
        && sleep_request |=> state_q != arbiter_pkg::ST_TO_SLP)
        else $error("sleep won over off");
    AST_BLOCK: assert property (in_off && off_lvl |=> in_off)
        else $error("on taken while off request present");
    AST_ZERO: assert property (in_run && zero_src |=> s_down_start)
        else $error("undelayed off source was delayed");
    AST_DELAY: assert property (state_q == arbiter_pkg::ST_DLY &&
        cnt_q != 32'h0 && !zero_src |=> state_q == arbiter_pkg::ST_DLY)
        else $error("switch-off delay cut short");
    AST_SHUT: assert property (dn_end && !seq_q.cold |=> in_off)
        else $error("shutdown did not stay off");
    AST_COLD: assert property (dn_end && seq_q.cold && !gate
        |=> s_up_start)
        else $error("cold restart did not power up");
    AST_WDOG: assert property (wd_to |=> wd_ev_q)
        else $error("watchdog timeout lost");
    AST_KEEP: assert property ((s_down_start and
        cause_q[`SRC_KEEP_LOST]) |-> !seq_q.wide && !seq_q.cold)
        else $error("keep-alive off not limited shutdown");
endmodule : power_on_off_request_arbiter
`default_nettype wire

/* File: src/arbiter_params.svh */
`ifndef ARBITER_PARAMS_SVH
`define ARBITER_PARAMS_SVH
// timing, in the unit of each name
`define CLK_HZ          40000000
`define HOLD_DEB_US     4000
`define RSTIN_OFF_US    1000
`define RSTIN_ON_US     26000
`define LONG_PRESS_MS   8000
`define DLY_UNIT_MS     1000
`define WDOG_UNIT_MS    1000
// register byte addresses
`define A_UNIT_CFG      8'h00
`define A_OFF_ACT       8'h04
`define A_DEPTH         8'h08
`define A_ON_SEL        8'h0C
`define A_CTRL          8'h10
`define A_WDOG          8'h14
`define A_KICK          8'h18
`define A_STATUS        8'h1C
// field positions
`define CFG_DLY_LSB     0
`define CFG_CONV_EN     2
`define CTRL_DEVICE_ON  0
`define CTRL_SOFT_RESET 1
`define WD_EN           0
`define WD_LOCK         1
`define WD_PER_LSB      2
// reset values
`define RV_UNIT_CFG     3'h0
`define RV_OFF_ACT      9'h000
`define RV_DEPTH        9'h000
`define RV_ON_SEL       8'h00
// off request sources
`define SRC_LONG_PRESS  0
`define SRC_POWER_DOWN  1
`define SRC_WATCHDOG    2
`define SRC_THERMAL     3
`define SRC_RESET_IN    4
`define SRC_SOFT_RESET  5
`define SRC_KEEP_LOST   6
`define SRC_SUPPLY_LOW  7
`define SRC_CONVERTER   8
`define SRC_N           9
`define DLY_MASK        9'h117
`define KEEP_MASK       9'h040
`define DLY_SEL_X4      2'h3
`endif

/* File: src/arbiter_pkg.sv */
package arbiter_pkg;
    typedef enum logic [7:0] {
        ST_OFF    = 8'h01,
        ST_UP     = 8'h02,
        ST_ACT    = 8'h04,
        ST_TO_SLP = 8'h08,
        ST_SLEEP  = 8'h10,
        ST_WAKE   = 8'h20,
        ST_DLY    = 8'h40,
        ST_DN     = 8'h80
    } state_type;
    typedef enum logic [2:0] {
        SEQ_NONE       = 3'h0,
        SEQ_OFF_TO_ACT = 3'h1,
        SEQ_ACT_TO_OFF = 3'h2,
        SEQ_SLP_TO_OFF = 3'h3,
        SEQ_ACT_TO_SLP = 3'h4,
        SEQ_SLP_TO_ACT = 3'h5
    } seq_kind_type;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_type;
    typedef struct packed {
        logic         start;
        seq_kind_type kind;
        logic         wide;
        logic         cold;
    } seq_req_type;
endpackage : arbiter_pkg

/* File: sim/seq_executor_model.sv */
`timescale 1ns/100ps
`default_nettype none

module seq_executor_model (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // sequencer link
    input  wire arbiter_pkg::seq_req_type seq_q,
    input  wire logic [3:0]               lat,
    output var  logic                     seq_done
);
    logic [4:0] left_q;
    // one done pulse lat+1 cycles after each start
    always_ff @(posedge clk) begin
        seq_done <= 1'h0;
        if (rst) begin
            left_q <= 5'h00;
        end else if (seq_q.start) begin
            left_q <= {1'h0, lat} + 5'h01;
        end else if (left_q != 5'h00) begin
            left_q   <= left_q - 5'h01;
            seq_done <= left_q == 5'h01;
        end
    end
endmodule : seq_executor_model
`default_nettype wire

/* File: sim/power_on_off_request_arbiter_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "arbiter_params.svh"

module power_on_off_request_arbiter_test;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } row_type;
    localparam row_type ROWS [6] = '{'{`A_UNIT_CFG, 32'h7, 32'h7},
        '{`A_OFF_ACT, 32'h1FF, 32'h1FF}, '{`A_DEPTH, 32'h1FF, 32'h1FF},
        '{`A_ON_SEL, 32'hFF, 32'hFF}, '{`A_WDOG, 32'h3C, 32'h3C},
        '{8'h20, 32'hFFFF, 32'h0}};
    localparam logic [3:0] GATE [4] = '{4'hB, 4'h7, 4'h1, 4'h2};
    localparam int HOLD_N = 8;
    localparam int RI_OFF_N = 4;
    localparam int RI_ON_N = 12;
    localparam int LONG_N = 20;
    localparam int DLY_N = 10;
    localparam int WDOG_N = 16;
    logic                     clk = 1'h0;
    logic                     rst = 1'h1;
    arbiter_pkg::reg_req_type reg_req = '0;
    logic [31:0]              rd_data;
    logic [31:0]              v;
    logic                     hold = 1'h0;
    logic                     pb = 1'h1;
    logic                     slo = 1'h0;
    logic                     conv = 1'h0;
    logic                     wake = 1'h0;
    // die_overtemp, power_down, supply_high_ok, reset_request
    logic [3:0]               gates = 4'h3;
    logic                     thermal = 1'h0;
    logic                     sleep_req = 1'h0;
    logic [7:0]               irq = 8'h00;
    logic [3:0]               lat = 4'h0;
    logic                     seq_done;
    arbiter_pkg::seq_req_type seq_q;
    arbiter_pkg::state_type   state_q;
    logic [8:0]               cause_q;
    int                       bad_count = 0;
    int                       checks_done = 0;

    power_on_off_request_arbiter #(.HOLD_DEB_CYC(HOLD_N),
        .RI_OFF_CYC(RI_OFF_N), .RI_ON_CYC(RI_ON_N),
        .LONG_PRESS_CYC(LONG_N), .DLY_UNIT_CYC(DLY_N),
        .WDOG_UNIT_CYC(WDOG_N)) i_dut (.clk(clk), .rst(rst),
        .reg_req(reg_req), .rd_data(rd_data), .power_button_input(pb),
        .hold_on_input(hold), .power_down_input(gates[2]),
        .reset_request_input(gates[0]), .supply_high_ok(gates[1]),
        .supply_low_fault(slo), .die_overtemp(gates[3]),
        .thermal_shutdown(thermal), .converter_shutdown_event(conv),
        .irq_lines(irq), .sleep_request(sleep_req), .wake_request(wake),
        .seq_done(seq_done), .seq_q(seq_q), .state_q(state_q),
        .cause_q(cause_q));
    seq_executor_model i_exec (.clk(clk), .rst(rst), .seq_q(seq_q),
        .lat(lat), .seq_done(seq_done));

    initial forever #12.5 clk = ~clk;

    task automatic conclude;
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk_val(input string n, input logic [31:0] e,
                           input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    task automatic chk_st(input arbiter_pkg::state_type s);
        chk_val("state", 32'(s), 32'(state_q));
    endtask : chk_st

    task automatic chk_seq(input arbiter_pkg::seq_kind_type k,
                           input logic w, input logic c);
        chk_val("seq", {27'h0, k, w, c},
                {27'h0, seq_q.kind, seq_q.wide, seq_q.cold});
    endtask : chk_seq

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one strobe cycle; read data lands in v
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        reg_req <= '{w, ~w, a, d};
        @(posedge clk);
        reg_req <= '0;
        #1 v = rd_data;
        @(posedge clk);
    endtask : bus

    task automatic wait_st(input arbiter_pkg::state_type s, input int n);
        for (int i = 0; i < n && state_q !== s; i++) begin
            @(posedge clk);
            #1;
        end
        chk_st(s);
        @(posedge clk);
    endtask : wait_st

    task automatic go_active;
        irq <= 8'h00;
        tick(4);
        irq <= 8'h01;
        wait_st(arbiter_pkg::ST_UP, 10);
        chk_seq(arbiter_pkg::SEQ_OFF_TO_ACT, 1'h0, 1'h0);
        wait_st(arbiter_pkg::ST_ACT, 30);
    endtask : go_active

    initial begin
        tick(6000);
        bad_count++;
        conclude();
    end

    initial begin
        tick(20);
        rst <= 1'h0;
        tick(3);
        foreach (ROWS[i]) begin
            bus(1'h0, ROWS[i].a, 32'h0);
            chk_val("reset", 32'h0, v);
            bus(1'h1, ROWS[i].a, ROWS[i].w);
            bus(1'h0, ROWS[i].a, 32'h0);
            chk_val("readback", ROWS[i].e, v);
        end
        chk_st(arbiter_pkg::ST_OFF);
        chk_val("seq", 32'h0, 32'(seq_q));
        bus(1'h1, `A_ON_SEL, 32'h1);
        bus(1'h1, `A_CTRL, 32'h1);
        foreach (GATE[g]) begin
            gates <= GATE[g];
            tick(20);
            irq <= 8'h01;
            tick(8);
            chk_st(arbiter_pkg::ST_OFF);
            irq <= 8'h00;
            gates <= 4'h3;
            tick(20);
        end
        go_active();
        lat <= 4'h9;
        sleep_req <= 1'h1;
        wait_st(arbiter_pkg::ST_SLEEP, 40);
        sleep_req <= 1'h0;
        bus(1'h1, `A_UNIT_CFG, 32'h3);
        bus(1'h1, `A_OFF_ACT, 32'h8);
        bus(1'h1, `A_DEPTH, 32'h8);
        thermal <= 1'h1;
        wait_st(arbiter_pkg::ST_DN, 8);
        thermal <= 1'h0;
        chk_seq(arbiter_pkg::SEQ_SLP_TO_OFF, 1'h1, 1'h1);
        chk_val("cause", 32'h8, 32'(cause_q));
        wait_st(arbiter_pkg::ST_UP, 30);
        wait_st(arbiter_pkg::ST_ACT, 30);
        bus(1'h0, `A_UNIT_CFG, 32'h0);
        chk_val("cfg", 32'h0, v);
        lat <= 4'h0;
        hold <= 1'h1;
        irq <= 8'h00;
        bus(1'h1, `A_UNIT_CFG, 32'h1);
        bus(1'h1, `A_ON_SEL, 32'h1);
        gates <= 4'h7;
        tick(2);
        sleep_req <= 1'h1;
        wait_st(arbiter_pkg::ST_DLY, 6);
        tick(7);
        chk_st(arbiter_pkg::ST_DLY);
        wait_st(arbiter_pkg::ST_DN, 6);
        chk_seq(arbiter_pkg::SEQ_ACT_TO_OFF, 1'h0, 1'h0);
        sleep_req <= 1'h0;
        wait_st(arbiter_pkg::ST_OFF, 6);
        tick(10);
        chk_st(arbiter_pkg::ST_OFF);
        gates <= 4'h3;
        wait_st(arbiter_pkg::ST_UP, 20);
        wait_st(arbiter_pkg::ST_ACT, 20);
        bus(1'h1, `A_CTRL, 32'h1);
        hold <= 1'h0;
        tick(20);
        chk_st(arbiter_pkg::ST_ACT);
        bus(1'h1, `A_OFF_ACT, 32'h1FF);
        bus(1'h1, `A_DEPTH, 32'h1FF);
        bus(1'h1, `A_CTRL, 32'h0);
        wait_st(arbiter_pkg::ST_DN, 6);
        chk_seq(arbiter_pkg::SEQ_ACT_TO_OFF, 1'h0, 1'h0);
        chk_val("cause", 32'h40, 32'(cause_q));
        wait_st(arbiter_pkg::ST_OFF, 6);
        bus(1'h1, `A_UNIT_CFG, 32'h0);
        bus(1'h1, `A_CTRL, 32'h1);
        go_active();
        sleep_req <= 1'h1;
        wait_st(arbiter_pkg::ST_SLEEP, 10);
        sleep_req <= 1'h0;
        wake <= 1'h1;
        wait_st(arbiter_pkg::ST_WAKE, 4);
        wake <= 1'h0;
        chk_seq(arbiter_pkg::SEQ_SLP_TO_ACT, 1'h0, 1'h0);
        wait_st(arbiter_pkg::ST_ACT, 6);
        bus(1'h1, `A_WDOG, 32'h3);
        bus(1'h1, `A_WDOG, 32'h0);
        bus(1'h0, `A_WDOG, 32'h0);
        chk_val("wdog", 32'h3, v);
        wait_st(arbiter_pkg::ST_DN, 20);
        chk_val("cause", 32'h4, 32'(cause_q));
        wait_st(arbiter_pkg::ST_ACT, 40);
        bus(1'h1, `A_UNIT_CFG, 32'h5);
        conv <= 1'h1;
        wait_st(arbiter_pkg::ST_DLY, 6);
        slo <= 1'h1;
        wait_st(arbiter_pkg::ST_DN, 6);
        chk_val("cause", 32'h180, 32'(cause_q));
        conv <= 1'h0;
        slo <= 1'h0;
        wait_st(arbiter_pkg::ST_OFF, 6);
        bus(1'h1, `A_CTRL, 32'h1);
        pb <= 1'h0;
        wait_st(arbiter_pkg::ST_ACT, 12);
        wait_st(arbiter_pkg::ST_DN, 40);
        chk_val("cause", 32'h1, 32'(cause_q));
        conclude();
    end
endmodule : power_on_off_request_arbiter_test
`default_nettype wire
